// File: rtl/cpe_datapath.sv
// Purpose: Arithmetic and register datapath driven by a microcode word.
// Assumes: Control fields are stable for the whole microinstruction.
// Notes:   Bit 32 of each stored word is its even parity bit.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "cpe_map.svh"
module cpe_datapath
  import cpe_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [5:0]    alu_func,
  input  wire logic          divide_active,
  input  wire cpe_asel_type  alu_a_sel,
  input  wire cpe_bsel_type  alu_b_sel,
  input  wire logic [5:0]    exp_func,
  input  wire cpe_easel_type exp_a_sel,
  input  wire cpe_ebsel_type exp_b_sel,
  input  wire logic          count_source_select,
  input  wire logic          exponent_load,
  input  wire cpe_raddr_type rf_addr_sel,
  input  wire logic [5:0]    rf_micro_addr,
  input  wire logic          rf_addr_increment,
  input  wire logic          float_op_flag,
  input  wire logic          regfile_write_enable,
  input  wire logic          regfile_read_check,
  input  wire cpe_rdata_type rf_data_sel,
  input  wire logic [1:0]    memory_bank_page,
  input  wire cpe_shift_type result_sel,
  input  wire logic          logical_shift_select,
  input  wire logic          result_load,
  input  wire cpe_shift_type addr_sel,
  input  wire logic          addr_load,
  input  wire cpe_qsel_type  quot_sel,
  input  wire logic          quot_load,
  input  wire logic          pair_shift_enable,
  input  wire logic          quotient_chain_enable,
  input  wire logic [7:0]    branch_address,
  input  wire logic [7:0]    shift_decode,
  input  wire logic [7:0]    normalize_out,
  input  wire logic [0:7]    shift_count_register,
  input  wire logic [0:47]   instruction_register,
  input  wire logic [0:39]   program_status_word,
  input  wire logic [0:32]   memory_read_data_register,
  input  wire logic          memory_read_check,
  output logic      [0:32]   data_result_register,
  output logic      [0:32]   address_register,
  output logic      [0:32]   quotient_work_register,
  output logic      [0:7]    exponent_register,
  output logic      [0:7]    exponent_sum,
  output logic               parity_error
);
  logic [0:31] panel_r;
  logic        rf_err_r;
  logic        mem_err_r;
  logic [31:0] prdata_r;
  logic [0:32] result_r;
  logic [0:32] addr_r;
  logic [0:32] quot_r;
  logic [0:7]  exponent_r;
  logic [0:32] rf_mem [0:`CPE_RF_WORDS-1];
  logic [0:32] rf_hold_r;
  logic [0:32] rf_raw;
  logic [0:32] rf_out;
  logic [5:0]  rf_addr;
  logic [3:0]  rf_field;
  logic [0:31] rf_wdata;
  logic [0:31] const_word;
  logic [0:31] alu_a;
  logic [0:31] alu_b;
  logic [0:31] alu_f;
  logic        alu_cout;
  logic        fn_mode;
  logic        fn_cin;
  logic [3:0]  fn_sel;
  logic [0:7]  exp_a;
  logic [0:7]  exp_b;
  logic [0:31] result_mux;
  logic [0:31] addr_mux;
  logic [0:31] quot_mux;
  logic        acc_w;
  logic        stat_clr;
  logic        rf_par_bad;
  logic        mem_par_bad;

  function automatic logic [0:31] cpe_shl(input logic [0:31] v,
                                          input logic [0:31] fill,
                                          input logic [3:0]  n);
    logic [0:63] t;
    t = {v, fill} << n;
    return t[0:31];
  endfunction

  function automatic logic [0:31] cpe_shr(input logic [0:31] v,
                                          input logic [0:31] fill,
                                          input logic [3:0]  n);
    logic [0:63] t;
    t = {fill, v} >> n;
    return t[32:63];
  endfunction

  function automatic logic [3:0] cpe_amt(input cpe_shift_type s);
    case (s)
      CPE_SH_L1, CPE_SH_R1: return 4'h1;
      CPE_SH_L4, CPE_SH_R4: return 4'h4;
      default:              return 4'h8;
    endcase
  endfunction

  // APB slave: read data is captured in the setup cycle, so the access
  // phase answers at once unless the clock enable holds everything.
  assign pready   = ce;
  assign acc_w    = psel && penable && pwrite && ce;
  assign stat_clr = acc_w && (paddr == `CPE_OFF_STATUS);
  assign pslverr  = psel && penable && (paddr != `CPE_OFF_PANEL) &&
                    (paddr != `CPE_OFF_STATUS) && (paddr != `CPE_OFF_EXPON);
  assign prdata   = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (ce && psel && !penable) begin
      case (paddr)
        `CPE_OFF_PANEL:  prdata_r <= panel_r;
        `CPE_OFF_STATUS: prdata_r <= {30'h00000000, mem_err_r, rf_err_r};
        `CPE_OFF_EXPON:  prdata_r <= {24'h000000, exponent_r};
        default:         prdata_r <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_r <= `CPE_PANEL_RST;
    end else if (acc_w && (paddr == `CPE_OFF_PANEL)) begin
      panel_r <= pwdata;
    end
  end

  // sticky parity flags
  // A new mismatch in the clearing cycle wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_err_r  <= 1'b0;
      mem_err_r <= 1'b0;
    end else if (ce) begin
      if (rf_par_bad) begin
        rf_err_r <= 1'b1;
      end else if (stat_clr && pwdata[`CPE_STAT_RF_ERR]) begin
        rf_err_r <= 1'b0;
      end
      if (mem_par_bad) begin
        mem_err_r <= 1'b1;
      end else if (stat_clr && pwdata[`CPE_STAT_MEM_ERR]) begin
        mem_err_r <= 1'b0;
      end
    end
  end
  assign parity_error = rf_err_r || mem_err_r;

  assign rf_par_bad  = regfile_read_check && (^rf_out);
  assign mem_par_bad = memory_read_check && (^memory_read_data_register);

  always_comb begin
    rf_field = 4'h0;
    rf_addr  = rf_micro_addr;
    case (rf_addr_sel)
      CPE_RA_R1:    rf_field = instruction_register[8:11];
      CPE_RA_R2:    rf_field = instruction_register[12:15];
      CPE_RA_B1:    rf_field = instruction_register[16:19];
      CPE_RA_B2:    rf_field = instruction_register[32:35];
      CPE_RA_PANEL: rf_addr  = panel_r[26:31];
      CPE_RA_QUOT:  rf_addr  = quot_r[26:31];
      default:      rf_addr  = rf_micro_addr;
    endcase
    if (rf_addr_sel inside {CPE_RA_R1, CPE_RA_R2, CPE_RA_B1,
                            CPE_RA_B2}) begin
      rf_addr = {2'b00, rf_field[3:1], rf_field[0] | rf_addr_increment} +
                (float_op_flag ? `CPE_FLOAT_OFFSET : 6'h00);
    end
  end

  assign const_word = `CPE_CONST_SEED >> rf_addr[3:0];
  assign rf_raw = (rf_addr < `CPE_CONST_BASE) ? rf_mem[rf_addr] :
                  {const_word, ^const_word};

  assign rf_out = regfile_write_enable ? rf_hold_r : rf_raw;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_hold_r <= `CPE_WORD_RST;
    end else if (ce) begin
      rf_hold_r <= rf_out;
    end
  end

  always_comb begin
    rf_wdata = 32'h00000000;
    case (rf_data_sel)
      CPE_RD_PANEL:  rf_wdata = panel_r;
      CPE_RD_RESULT: rf_wdata = result_r[0:31];
      CPE_RD_ADDR:   rf_wdata = addr_r[0:31];
      CPE_RD_QUOT:   rf_wdata = quot_r[0:31];
      CPE_RD_SHIFT:  rf_wdata = result_mux;
      CPE_RD_BANK:   rf_wdata[16:17] = memory_bank_page;
      default:       rf_wdata = 32'h00000000;
    endcase
  end

  // file write on the clock edge
  always_ff @(posedge pclk) begin
    if (ce && regfile_write_enable && (rf_addr < `CPE_CONST_BASE)) begin
      rf_mem[rf_addr] <= {rf_wdata, ^rf_wdata};
    end
  end

  always_comb begin
    case (alu_a_sel)
      CPE_A_RESULT: alu_a = result_r[0:31];
      CPE_A_ADDR:   alu_a = addr_r[0:31];
      CPE_A_RF:     alu_a = rf_out[0:31];
      CPE_A_EXPRES: alu_a = {exponent_r, result_r[8:31]};
      default:      alu_a = 32'h00000000;
    endcase
  end

  always_comb begin
    case (alu_b_sel)
      CPE_B_MEM:   alu_b = memory_read_data_register[0:31];
      CPE_B_HALF:  alu_b = {{16{memory_read_data_register[16]}},
                            memory_read_data_register[16:31]};
      CPE_B_RF:    alu_b = rf_out[0:31];
      CPE_B_DISP:  alu_b = {20'h00000, instruction_register[20:31]};
      CPE_B_OPIMM: alu_b = {instruction_register[0:7], 16'h0000,
                            instruction_register[8:15]};
      CPE_B_PSW1:  alu_b = {program_status_word[0:15], rf_out[16:31]};
      CPE_B_PSW2:  alu_b = {1'b0, program_status_word[33:39],
                            rf_out[8:31]};
      default:     alu_b = 32'h00000000;
    endcase
  end

  always_comb begin
    if (divide_active) begin
      fn_mode = 1'b0;
      fn_cin  = ~quot_r[31];
      fn_sel  = quot_r[31] ? `CPE_FN_ADD : `CPE_FN_SUB;
    end else begin
      fn_mode = alu_func[5];
      fn_cin  = alu_func[4];
      fn_sel  = alu_func[3:0];
    end
  end

  cpe_func_unit #(.W(32)) u_main (
    .a    (alu_a),
    .b    (alu_b),
    .mode (fn_mode),
    .cin  (fn_cin),
    .sel  (fn_sel),
    .f    (alu_f),
    .cout (alu_cout)
  );

  always_comb begin
    case (exp_a_sel)
      CPE_EA_EXP:   exp_a = exponent_r;
      CPE_EA_SHIFT: exp_a = shift_count_register;
      default:      exp_a = 8'h00;
    endcase
    case (exp_b_sel)
      CPE_EB_MEM:   exp_b = {1'b0, memory_read_data_register[1:7]};
      CPE_EB_RF:    exp_b = {1'b0, rf_out[1:7]};
      CPE_EB_EXP:   exp_b = exponent_r;
      CPE_EB_CHAR:  exp_b = {2'b00, shift_count_register[0:5]};
      CPE_EB_COUNT: exp_b = count_source_select ? shift_decode :
                                                  branch_address;
      CPE_EB_NORM:  exp_b = normalize_out;
      default:      exp_b = 8'h00;
    endcase
  end

  cpe_func_unit #(.W(8)) u_exp (
    .a    (exp_a),
    .b    (exp_b),
    .mode (exp_func[5]),
    .cin  (exp_func[4]),
    .sel  (exp_func[3:0]),
    .f    (exponent_sum),
    .cout ()
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exponent_r <= `CPE_EXP_RST;
    end else if (ce && exponent_load) begin
      exponent_r <= exponent_sum;
    end
  end
  assign exponent_register = exponent_r;

  // result mux with pair fill on left shifts
  always_comb begin
    case (result_sel)
      CPE_SH_PASS: result_mux = alu_f;
      CPE_SH_L1, CPE_SH_L4, CPE_SH_L8:
        result_mux = cpe_shl(alu_f, pair_shift_enable ? addr_r[0:31] :
                             32'h00000000, cpe_amt(result_sel));
      CPE_SH_R1, CPE_SH_R4, CPE_SH_R8:
        result_mux = cpe_shr(alu_f, logical_shift_select ? 32'h00000000 :
                             {32{alu_f[0]}}, cpe_amt(result_sel));
      default:     result_mux = 32'h00000000;
    endcase
  end

  // address mux, chained to both neighbours
  always_comb begin
    case (addr_sel)
      CPE_SH_PASS: addr_mux = result_mux;
      CPE_SH_L1, CPE_SH_L4, CPE_SH_L8:
        addr_mux = cpe_shl(addr_r[0:31], quotient_chain_enable ?
                           quot_r[0:31] : 32'h00000000, cpe_amt(addr_sel));
      CPE_SH_R1, CPE_SH_R4, CPE_SH_R8:
        addr_mux = cpe_shr(addr_r[0:31], pair_shift_enable ?
                           result_r[0:31] : 32'h00000000, cpe_amt(addr_sel));
      default:     addr_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    case (quot_sel)
      CPE_Q_L1:     quot_mux = {quot_r[1:31], 1'b0};
      CPE_Q_R1:     quot_mux = {quotient_chain_enable & addr_r[31],
                                quot_r[0:30]};
      CPE_Q_CARRY:  quot_mux = {quot_r[1:31], alu_cout};
      CPE_Q_RESULT: quot_mux = result_mux;
      default:      quot_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r <= `CPE_WORD_RST;
      addr_r   <= `CPE_WORD_RST;
      quot_r   <= `CPE_WORD_RST;
    end else if (ce) begin
      if (result_load) begin
        result_r <= {result_mux, ^result_mux};
      end
      if (addr_load) begin
        addr_r <= {addr_mux, ^addr_mux};
      end
      if (quot_load) begin
        quot_r <= {quot_mux, ^quot_mux};
      end
    end
  end
  assign data_result_register   = result_r;
  assign address_register       = addr_r;
  assign quotient_work_register = quot_r;

  logic [0:31] chk_sum;
  logic [0:31] chk_diff;
  assign chk_sum  = alu_a + alu_b;
  assign chk_diff = alu_a - alu_b;

  default clocking cpe_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence cpe_write_run;
    ce && regfile_write_enable ##1 regfile_write_enable;
  endsequence

  AST_DIV_ADD: assert property (divide_active && quot_r[31] |->
    alu_f == chk_sum) else $error("divide add not forced");
  AST_DIV_SUB: assert property (divide_active && !quot_r[31] |->
    alu_f == chk_diff) else $error("divide subtract not forced");
  AST_ER_HOLD: assert property (ce && !exponent_load |=>
    $stable(exponent_register)) else $error("exponent changed");
  AST_EXPONENT_LOAD: assert property (ce && exponent_load |=>
    exponent_register == $past(exponent_sum))
    else $error("exponent not loaded");
  AST_PARITY_GEN: assert property (ce && result_load |=>
    !(^data_result_register)) else $error("result parity wrong");
  AST_RF_LATCH: assert property (cpe_write_run |->
    rf_out == $past(rf_out)) else $error("file latch moved");
  AST_ERR_STICKY: assert property (parity_error && !stat_clr |=>
    parity_error) else $error("parity flag lost");
  AST_FLOAT_ADDR: assert property (rf_addr_sel == CPE_RA_R1 &&
    float_op_flag && !rf_addr_increment |->
    rf_addr == {2'b01, instruction_register[8:11]})
    else $error("float address offset wrong");
  AST_PAIR_LEFT: assert property (ce && result_load &&
    pair_shift_enable && result_sel == CPE_SH_L1 |=>
    data_result_register[31] == $past(addr_r[0]))
    else $error("pair shift fill wrong");
endmodule

// File: rtl/cpe_func_unit.sv
// Purpose: Function-table adder slice used by both arithmetic units.
// Assumes: mode high selects logic operations, cin is the forced carry.
// Notes:   Select 1001 adds, 0110 with carry in subtracts.
`timescale 1ns/100ps
module cpe_func_unit #(
  parameter int W = 32
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         mode,
  input  wire logic         cin,
  input  wire logic [3:0]   sel,
  output logic      [W-1:0] f,
  output logic              cout
);
  logic [W-1:0] u;
  logic [W-1:0] v;
  logic [W:0]   sum;

  // Arithmetic result is v plus u plus carry; logic result is their XNOR.
  assign u    = a | (b & {W{sel[0]}}) | (~b & {W{sel[1]}});
  assign v    = (a & ~b & {W{sel[2]}}) | (a & b & {W{sel[3]}});
  assign sum  = {1'b0, v} + {1'b0, u} + {{W{1'b0}}, cin};
  assign f    = mode ? ~(u ^ v) : sum[W-1:0];
  assign cout = mode ? 1'b0 : sum[W];
endmodule

// File: rtl/cpe_map.svh
// Purpose: Offsets, field positions, reset values and fixed codes.
// Assumes: Included by bare name from the datapath design files.
// Notes:   Definitions only.
`ifndef CPE_MAP_SVH
`define CPE_MAP_SVH
`define CPE_OFF_PANEL      8'h00
`define CPE_OFF_STATUS     8'h04
`define CPE_OFF_EXPON      8'h08
`define CPE_STAT_RF_ERR    0
`define CPE_STAT_MEM_ERR   1
`define CPE_RF_WORDS       48
`define CPE_CONST_BASE     6'h30
`define CPE_FLOAT_OFFSET   6'h10
`define CPE_CONST_SEED     32'hFFFFFFFF
`define CPE_FN_ADD         4'h9
`define CPE_FN_SUB         4'h6
`define CPE_PANEL_RST      32'h00000000
`define CPE_EXP_RST        8'h00
`define CPE_WORD_RST       33'h000000000
`endif

// File: rtl/cpe_pkg.sv
// Purpose: Select-field encodings of the datapath control word.
// Assumes: Codes not listed select zero, except file address code 7, which selects rf_micro_addr.
// Notes:   Bit 0 of every datapath word is its most significant bit.
package cpe_pkg;
  typedef enum logic [2:0] {
    CPE_A_ZERO = 3'h0, CPE_A_RESULT = 3'h1, CPE_A_ADDR = 3'h2,
    CPE_A_RF = 3'h3, CPE_A_EXPRES = 3'h4
  } cpe_asel_type;
  typedef enum logic [2:0] {
    CPE_B_MEM = 3'h0, CPE_B_HALF = 3'h1, CPE_B_RF = 3'h2,
    CPE_B_DISP = 3'h3, CPE_B_OPIMM = 3'h4, CPE_B_PSW1 = 3'h5,
    CPE_B_PSW2 = 3'h6, CPE_B_ZERO = 3'h7
  } cpe_bsel_type;
  typedef enum logic [2:0] {
    CPE_SH_ZERO = 3'h0, CPE_SH_PASS = 3'h1, CPE_SH_L1 = 3'h2,
    CPE_SH_L4 = 3'h3, CPE_SH_L8 = 3'h4, CPE_SH_R1 = 3'h5,
    CPE_SH_R4 = 3'h6, CPE_SH_R8 = 3'h7
  } cpe_shift_type;
  typedef enum logic [2:0] {
    CPE_Q_ZERO = 3'h0, CPE_Q_L1 = 3'h1, CPE_Q_R1 = 3'h2,
    CPE_Q_CARRY = 3'h3, CPE_Q_RESULT = 3'h4
  } cpe_qsel_type;
  typedef enum logic [2:0] {
    CPE_RA_R1 = 3'h0, CPE_RA_R2 = 3'h1, CPE_RA_B1 = 3'h2,
    CPE_RA_B2 = 3'h3, CPE_RA_PANEL = 3'h4, CPE_RA_QUOT = 3'h5,
    CPE_RA_MICRO = 3'h6
  } cpe_raddr_type;
  typedef enum logic [2:0] {
    CPE_RD_PANEL = 3'h0, CPE_RD_RESULT = 3'h1, CPE_RD_ADDR = 3'h2,
    CPE_RD_QUOT = 3'h3, CPE_RD_SHIFT = 3'h4, CPE_RD_BANK = 3'h5
  } cpe_rdata_type;
  typedef enum logic [1:0] {
    CPE_EA_ZERO = 2'h0, CPE_EA_EXP = 2'h1, CPE_EA_SHIFT = 2'h2
  } cpe_easel_type;
  typedef enum logic [2:0] {
    CPE_EB_MEM = 3'h0, CPE_EB_RF = 3'h1, CPE_EB_EXP = 3'h2,
    CPE_EB_CHAR = 3'h3, CPE_EB_COUNT = 3'h4, CPE_EB_NORM = 3'h5
  } cpe_ebsel_type;
endpackage

// File: verification/cpe_mem_model.sv
// Purpose: Memory read word source for the datapath, with even parity.
// Assumes: The parity bit makes the XOR of all 33 bits zero.
// Notes:   bad inverts the parity bit so that a check must fail.
`timescale 1ns/100ps
module cpe_mem_model (
  input  wire logic [31:0] word,
  input  wire logic        bad,
  output logic      [0:32] mem_word
);
  assign mem_word = {word, (^word) ^ bad};
endmodule

// File: verification/tb.sv
// Purpose: Self-checking bench for the arithmetic register datapath.
// Assumes: ce stays high; inputs change by NBA just after rising edges.
// Notes:   Expected values come from the small reference model below.
`timescale 1ns/100ps
module tb;
  import cpe_pkg::*;
  logic pclk = '0, presetn = '0, ce = '1, psel = '0, penable = '0;
  logic pwrite = '0, pready, pslverr, parity_error, e, bad = '0;
  logic [7:0] paddr = '0, branch_address = '0, shift_decode = '0;
  logic [7:0] normalize_out = '0, ba, sd, x;
  logic [31:0] pwdata = '0, prdata, w = '0, m, q, r;
  logic [5:0] alu_func = '0, exp_func = '0, rf_micro_addr = '0;
  logic divide_active = '0, count_source_select = '0, exponent_load = '0;
  logic rf_addr_increment = '0, float_op_flag = '0;
  logic regfile_write_enable = '0, regfile_read_check = '0;
  logic logical_shift_select = '0, result_load = '0, addr_load = '0;
  logic quot_load = '0, pair_shift_enable = '0, memory_read_check = '0;
  logic quotient_chain_enable = '0;
  logic [1:0] memory_bank_page = '0;
  logic [0:7] shift_count_register = '0, exponent_register, exponent_sum;
  logic [0:47] instruction_register = '0;
  logic [0:39] program_status_word = '0;
  logic [0:32] memory_read_data_register, data_result_register;
  logic [0:32] address_register, quotient_work_register;
  cpe_asel_type alu_a_sel = CPE_A_ZERO;
  cpe_bsel_type alu_b_sel = CPE_B_ZERO;
  cpe_easel_type exp_a_sel = CPE_EA_ZERO;
  cpe_ebsel_type exp_b_sel = CPE_EB_COUNT;
  cpe_raddr_type rf_addr_sel = CPE_RA_MICRO;
  cpe_rdata_type rf_data_sel = CPE_RD_RESULT;
  cpe_shift_type result_sel = CPE_SH_PASS, addr_sel = CPE_SH_ZERO;
  cpe_qsel_type quot_sel = CPE_Q_ZERO;
  int err_count = 0, samples_checked = 0;
  int amt [8] = '{0, 0, 1, 4, 8, 1, 4, 8};
  logic [5:0] fn [5] = '{6'h09, 6'h16, 6'h2B, 6'h2E, 6'h26};

  cpe_datapath dut (.*);
  cpe_mem_model mem (.word(w), .bad(bad),
                     .mem_word(memory_read_data_register));

  always #2.5 pclk = ~pclk;

  function automatic logic [31:0] alu(input logic [5:0] f,
                                      input logic [31:0] a, b);
    case (f)
      6'h09: return a + b;
      6'h16: return a - b;
      6'h2B: return a & b;
      6'h2E: return a | b;
      default: return a ^ b;
    endcase
  endfunction

  task automatic check(input string nm, input logic [32:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Lets the loading edge pass, then drops every one-cycle strobe.
  task automatic fin;
    @(posedge pclk);
    result_load <= '0;
    addr_load <= '0;
    quot_load <= '0;
    exponent_load <= '0;
    regfile_write_enable <= '0;
    memory_read_check <= '0;
    bad <= '0;
    divide_active <= '0;
    #1;
  endtask

  task automatic go(input cpe_asel_type as, input cpe_bsel_type bs,
                    input logic [5:0] f, input cpe_shift_type sh,
                    input logic ls);
    @(posedge pclk);
    alu_a_sel <= as;
    alu_b_sel <= bs;
    alu_func <= f;
    result_sel <= sh;
    logical_shift_select <= ls;
    w <= m;
    result_load <= '1;
    fin;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge pclk);
    psel <= '1;
    penable <= '0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= '1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= '0;
    penable <= '0;
  endtask

  initial begin
    #20000;
    err_count++;
    complete_run;
  end

  initial begin
    void'($urandom(32'h7C79));
    repeat (20) @(posedge pclk);
    presetn <= '1;
    @(posedge pclk);
    #1;
    check("result", data_result_register, '0);
    check("perr", parity_error, '0);
    m = $urandom();
    go(CPE_A_ZERO, CPE_B_HALF, 6'h09, CPE_SH_PASS, '0);
    check("half", data_result_register,
          {{16{m[15]}}, m[15:0], ^m[15:0]});
    go(CPE_A_ZERO, CPE_B_MEM, 6'h09, CPE_SH_PASS, '0);
    r = m;
    check("load", data_result_register, {r, ^r});
    foreach (fn[i]) begin
      m = $urandom();
      go(CPE_A_RESULT, CPE_B_MEM, fn[i], CPE_SH_PASS, '0);
      r = alu(fn[i], r, m);
      check("alu", data_result_register, {r, ^r});
    end
    m = $urandom();
    @(posedge pclk);
    divide_active <= '1;
    go(CPE_A_RESULT, CPE_B_MEM, 6'h2B, CPE_SH_PASS, '0);
    r = r - m;
    check("divide", data_result_register, {r, ^r});
    $display("alu test done");
    for (int s = 2; s < 8; s++)
      for (int l = 0; l < 2; l++) begin
        m = $urandom() | 32'h80000000;
        go(CPE_A_ZERO, CPE_B_MEM, 6'h09, cpe_shift_type'(s), l[0]);
        if (s < 5)
          r = m << amt[s];
        else if (l)
          r = m >> amt[s];
        else
          r = $signed(m) >>> amt[s];
        check("shift", data_result_register, {r, ^r});
      end
    $display("shift test done");
    @(posedge pclk);
    rf_micro_addr <= 6'h25;
    regfile_write_enable <= '1;
    fin;
    go(CPE_A_ZERO, CPE_B_ZERO, 6'h09, CPE_SH_PASS, '0);
    @(posedge pclk);
    regfile_read_check <= '1;
    go(CPE_A_RF, CPE_B_ZERO, 6'h09, CPE_SH_PASS, '0);
    check("rf", data_result_register, {r, ^r});
    check("rf perr", parity_error, '0);
    $display("regfile test done");
    m = $urandom() | 32'h80000001;
    @(posedge pclk);
    alu_a_sel <= CPE_A_ZERO;
    alu_b_sel <= CPE_B_MEM;
    result_sel <= CPE_SH_PASS;
    addr_sel <= CPE_SH_PASS;
    quot_sel <= CPE_Q_RESULT;
    w <= m;
    {result_load, addr_load, quot_load} <= 3'h7;
    fin;
    check("addr", address_register, {m, ^m});
    check("quot", quotient_work_register, {m, ^m});
    @(posedge pclk);
    alu_a_sel <= CPE_A_RESULT;
    alu_b_sel <= CPE_B_ZERO;
    result_sel <= CPE_SH_L1;
    addr_sel <= CPE_SH_R1;
    pair_shift_enable <= '1;
    {result_load, addr_load} <= 2'h3;
    fin;
    r = {m[30:0], m[31]};
    q = {m[0], m[31:1]};
    check("pair left", data_result_register, {r, ^r});
    check("pair right", address_register, {q, ^q});
    m = $urandom();
    @(posedge pclk);
    pair_shift_enable <= '0;
    divide_active <= '1;
    go(CPE_A_RESULT, CPE_B_MEM, 6'h2B, CPE_SH_PASS, '0);
    r = r + m;
    check("divide add", data_result_register, {r, ^r});
    @(posedge pclk);
    instruction_register[8:11] <= 4'h5;
    rf_addr_sel <= CPE_RA_R1;
    float_op_flag <= '1;
    regfile_write_enable <= '1;
    @(posedge pclk);
    fin;
    @(posedge pclk);
    rf_addr_sel <= CPE_RA_MICRO;
    rf_micro_addr <= 6'h15;
    float_op_flag <= '0;
    go(CPE_A_RF, CPE_B_ZERO, 6'h09, CPE_SH_PASS, '0);
    check("float rf", data_result_register, {r, ^r});
    go(CPE_A_ZERO, CPE_B_OPIMM, 6'h09, CPE_SH_PASS, '0);
    check("opimm", data_result_register, {32'h00000050, 1'b0});
    $display("pair and address test done");
    for (int c = 0; c < 2; c++) begin
      ba = 8'($urandom());
      sd = 8'($urandom());
      @(posedge pclk);
      branch_address <= ba;
      shift_decode <= sd;
      count_source_select <= c[0];
      exp_func <= 6'h09;
      exponent_load <= '1;
      fin;
      x = c ? sd : ba;
      check("exp", exponent_register, x);
    end
    ba = 8'($urandom());
    @(posedge pclk);
    exp_a_sel <= CPE_EA_EXP;
    exp_func <= 6'h16;
    count_source_select <= '0;
    branch_address <= ba;
    fin;
    check("esum", exponent_sum, 8'(x - ba));
    check("ehold", exponent_register, x);
    apb('0, 8'h08, '0, q, e);
    check("exp rd", q, {24'h000000, x});
    $display("exponent test done");
    @(posedge pclk);
    bad <= '1;
    memory_read_check <= '1;
    fin;
    check("perr", parity_error, 1'b1);
    apb('0, 8'h04, '0, q, e);
    check("status", q, 32'h00000002);
    apb('1, 8'h04, 32'h00000002, q, e);
    #1;
    check("clear", parity_error, '0);
    m = $urandom();
    apb('1, 8'h00, m, q, e);
    apb('0, 8'h00, '0, q, e);
    check("panel", q, m);
    apb('0, 8'h0C, '0, q, e);
    check("unmapped", {e, q}, 33'h100000000);
    $display("parity and bus test done");
    complete_run;
  end
endmodule
